// >>> rtl/idc_dcr_cal.sv
// Purpose: register file, bring-up gate, resistance gain calibration and thermal estimate
// Assumes: telemetry inputs are synchronous readings already scaled by the converter front end
// Notes: duty is a Q0.16 fraction, currents in mA, temperatures Q8.8 degC signed
`timescale 1ns/1ps
module idc_dcr_cal
  import idc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire idc_axi_req_t axi_req,
  output idc_axi_rsp_t axi_rsp,
  input wire idc_telem_t telem,
  input wire logic main_supply_ok,
  input wire logic pwm_enabled,
  output logic pwm_allowed,
  output logic adc_valid,
  output logic nvm_store_req,
  output logic [15:0] iout_gain,
  output logic [15:0] rdcr_est,
  output logic irq
);
  typedef struct packed {
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic armed;
    logic unlocked;
    logic restart_need;
    logic store;
    logic [7:0] mode;
    logic [15:0] gain;
    logic [15:0] uncal;
    logic [1:0] status;
    logic [1:0] mask;
    logic [15:0] r0;
    logic [15:0] alpha;
    logic [15:0] theta;
    logic [15:0] tref;
    logic [3:0] tau;
    logic [31:0] tick_cnt;
    logic [15:0] rise;
    logic [15:0] rdcr;
    idc_cal_t cal;
    logic [31:0] settle;
    logic div_go;
  } idc_main_t;

  idc_main_t st_ff, nxt_st;

  logic wr_fire, wr_ok, rd_fire, div_busy, div_done, pre_ok, in_window;
  logic [7:0] wr_addr;
  logic [31:0] wr_data, wr_mask, rd_val;
  logic [47:0] div_num, div_quot;
  logic [31:0] div_den, pwr;
  logic [47:0] pwr_th;
  logic [15:0] rise_ss;
  logic signed [16:0] rise_diff;
  logic signed [17:0] dtemp, corr;
  logic signed [33:0] alpha_dt;
  logic signed [34:0] r0_corr;
  logic [19:0] q_x10;
  logic [19:0] lo_lim, hi_lim;
  logic [1:0] st_set;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [31:0] m);
    merge16 = (old & ~m[15:0]) | (d[15:0] & m[15:0]);
  endfunction : merge16

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_mask[i*8 +: 8] = {8{st_ff.w_strb[i]}};
    end
  end

  assign wr_fire = st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid;
  assign wr_addr = st_ff.aw_addr;
  assign wr_data = st_ff.w_data;
  // registers other than the unlock port are shut while only the aux pin powers the part, unless the unlock sequence has completed
  assign wr_ok = st_ff.unlocked || main_supply_ok;
  assign rd_fire = axi_req.arvalid && !st_ff.rvalid;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (axi_req.araddr)
      A_UNLOCK: rd_val = {31'h0, st_ff.unlocked};
      A_CMD: rd_val = 32'h0000_0000;
      A_MODE: rd_val = {24'h00_0000, st_ff.mode};
      A_GAIN: rd_val = {16'h0000, st_ff.gain};
      A_UNCAL: rd_val = {16'h0000, st_ff.uncal};
      A_STATUS: rd_val = {30'h0, st_ff.status};
      A_MASK: rd_val = {30'h0, st_ff.mask};
      A_STATE: rd_val = {28'h000_0000, st_ff.cal != CAL_IDLE, st_ff.restart_need, main_supply_ok, st_ff.unlocked};
      A_R0: rd_val = {16'h0000, st_ff.r0};
      A_ALPHA: rd_val = {16'h0000, st_ff.alpha};
      A_THETA: rd_val = {16'h0000, st_ff.theta};
      A_TREF: rd_val = {16'h0000, st_ff.tref};
      A_TAU: rd_val = {28'h000_0000, st_ff.tau};
      A_RDCR: rd_val = {16'h0000, st_ff.rdcr};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // gain' = gain * iin / (iout * duty); duty is Q0.16 so the numerator carries 16 extra bits
  assign div_num = {32'(st_ff.gain) * 32'(telem.iin), 16'h0000};
  assign div_den = telem.iout * telem.duty;
  assign pre_ok = pwm_enabled && (telem.duty >= DUTY_MIN_Q16) && (telem.iin >= IIN_MIN_MA)
    && (div_den != 32'h0000_0000);
  assign q_x10 = 20'(div_quot[15:0]) * 20'd10;
  assign lo_lim = 20'(st_ff.uncal) * 20'(WIN_LO_TENTHS);
  assign hi_lim = 20'(st_ff.uncal) * 20'(WIN_HI_TENTHS);
  assign in_window = (div_quot[47:16] == 32'h0000_0000) && (q_x10 >= lo_lim) && (q_x10 <= hi_lim);

  idc_seq_div #(.NW(48), .DW(32)) u_div (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(st_ff.div_go),
    .num(div_num),
    .den(div_den),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot)
  );

  // thermal model: steady rise = theta * vdcr * iout, then a one-pole lag with 2^tau ticks
  assign pwr = telem.vdcr * telem.iout;
  assign pwr_th = 48'(pwr) * 48'(st_ff.theta);
  assign rise_ss = (pwr_th[47:PWR_SHIFT+16] != '0) ? 16'hFFFF : pwr_th[PWR_SHIFT +: 16];
  assign rise_diff = $signed({1'b0, rise_ss}) - $signed({1'b0, st_ff.rise});
  assign dtemp = 18'($signed(telem.temp_s)) - 18'($signed(st_ff.tref)) + $signed({2'b00, st_ff.rise});
  assign alpha_dt = $signed({2'b00, st_ff.alpha}) * dtemp;
  assign corr = 18'(alpha_dt >>> FRAC_SHIFT);
  assign r0_corr = $signed({1'b0, st_ff.r0}) * corr;

  always_comb begin
    logic signed [18:0] est;
    logic signed [16:0] step;
    est = 19'($signed({1'b0, st_ff.r0})) + 19'(r0_corr >>> FRAC_SHIFT);
    step = rise_diff >>> st_ff.tau;
    if (step == 17'sd0 && rise_diff != 17'sd0) begin
      step = (rise_diff > 0) ? 17'sd1 : -17'sd1;
    end
    st_set = 2'b00;
    nxt_st = st_ff;
    nxt_st.store = 1'b0;
    nxt_st.div_go = 1'b0;
    // AXI write channels taken in either order
    if (axi_req.awvalid && !st_ff.aw_hold) begin
      nxt_st.aw_hold = 1'b1;
      nxt_st.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st_ff.w_hold) begin
      nxt_st.w_hold = 1'b1;
      nxt_st.w_data = axi_req.wdata;
      nxt_st.w_strb = axi_req.wstrb;
    end
    if (st_ff.bvalid && axi_req.bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (rd_fire) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_val;
      nxt_st.rresp = (axi_req.araddr > A_RDCR || axi_req.araddr[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
    end else if (st_ff.rvalid && axi_req.rready) begin
      nxt_st.rvalid = 1'b0;
    end
    // thermal lag tick and resistance estimate
    if (st_ff.tick_cnt >= TICK_CYCLES - 1) begin
      nxt_st.tick_cnt = 32'h0000_0000;
      nxt_st.rise = 16'(17'($signed({1'b0, st_ff.rise})) + step);
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 32'h0000_0001;
    end
    nxt_st.rdcr = (est < 0) ? 16'h0000 : ((est > 19'sh0FFFF) ? 16'hFFFF : est[15:0]);
    // main supply loss forces a restart before switching resumes
    if (!main_supply_ok) begin
      nxt_st.restart_need = 1'b1;
    end
    // calibration sequence
    case (st_ff.cal)
      CAL_IDLE: nxt_st.settle = 32'h0000_0000;
      CAL_SETTLE: begin
        // measurements are only trusted once the operating point has held for the settle time
        nxt_st.settle = st_ff.settle + 32'h0000_0001;
        if (st_ff.settle >= SETTLE_CYCLES - 1) begin
          nxt_st.cal = CAL_CHECK;
        end
      end
      CAL_CHECK: begin
        if (!pre_ok) begin
          st_set[ST_FAIL_BIT] = 1'b1;
          nxt_st.cal = CAL_END;
        end else if (!div_busy) begin
          // a divider still running for an aborted run would hand back a stale quotient
          nxt_st.div_go = 1'b1;
          nxt_st.cal = CAL_DIV;
        end
      end
      CAL_DIV: begin
        if (div_done) begin
          if (in_window) begin
            nxt_st.gain = div_quot[15:0];
            st_set[ST_PASS_BIT] = 1'b1;
          end else begin
            st_set[ST_FAIL_BIT] = 1'b1;
          end
          nxt_st.cal = CAL_END;
        end
      end
      CAL_END: begin
        nxt_st.mode[CAL_START_BIT] = 1'b0;
        nxt_st.cal = CAL_IDLE;
      end
      default: nxt_st.cal = CAL_IDLE;
    endcase
    // register writes
    if (wr_fire) begin
      nxt_st.aw_hold = 1'b0;
      nxt_st.w_hold = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = (wr_addr > A_RDCR || wr_addr[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
      if (wr_addr == A_UNLOCK && st_ff.w_strb[0]) begin
        nxt_st.armed = (wr_data[7:0] == UNLOCK_CODE1);
        if (st_ff.armed && wr_data[7:0] == UNLOCK_CODE2) begin
          nxt_st.unlocked = 1'b1;
        end
      end else if (wr_ok) begin
        case (wr_addr)
          A_CMD: begin
            nxt_st.store = wr_data[CMD_STORE_BIT] && st_ff.w_strb[0];
            if (wr_data[CMD_RESTART_BIT] && st_ff.w_strb[0] && main_supply_ok) begin
              // restart drops any calibration in flight; the old gain stays
              nxt_st.restart_need = 1'b0;
              nxt_st.cal = CAL_IDLE;
              nxt_st.mode[CAL_START_BIT] = 1'b0;
            end
          end
          A_MODE: begin
            if (st_ff.cal == CAL_IDLE) begin
              nxt_st.mode = (st_ff.mode & ~wr_mask[7:0]) | (wr_data[7:0] & wr_mask[7:0]);
              if (wr_data[CAL_START_BIT] && st_ff.w_strb[0]) begin
                nxt_st.cal = CAL_SETTLE;
              end
            end
          end
          A_GAIN: if (st_ff.cal == CAL_IDLE) nxt_st.gain = merge16(st_ff.gain, wr_data, wr_mask);
          A_UNCAL: nxt_st.uncal = merge16(st_ff.uncal, wr_data, wr_mask);
          A_STATUS: nxt_st.status = st_ff.status & ~(wr_data[1:0] & wr_mask[1:0]);
          A_MASK: nxt_st.mask = (st_ff.mask & ~wr_mask[1:0]) | (wr_data[1:0] & wr_mask[1:0]);
          A_R0: nxt_st.r0 = merge16(st_ff.r0, wr_data, wr_mask);
          A_ALPHA: nxt_st.alpha = merge16(st_ff.alpha, wr_data, wr_mask);
          A_THETA: nxt_st.theta = merge16(st_ff.theta, wr_data, wr_mask);
          A_TREF: nxt_st.tref = merge16(st_ff.tref, wr_data, wr_mask);
          A_TAU: if (st_ff.w_strb[0]) nxt_st.tau = wr_data[3:0];
          default: nxt_st.tau = nxt_st.tau;
        endcase
      end
    end
    // a new event wins over a clear in the same cycle
    nxt_st.status = nxt_st.status | st_set;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
      st_ff.gain <= GAIN_RST;
      st_ff.uncal <= GAIN_RST;
      st_ff.r0 <= R0_RST;
      st_ff.alpha <= ALPHA_RST;
      st_ff.theta <= THETA_RST;
      st_ff.tref <= TREF_RST;
      st_ff.tau <= TAU_RST;
      st_ff.rdcr <= R0_RST;
      st_ff.cal <= CAL_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign axi_rsp.awready = !st_ff.aw_hold;
  assign axi_rsp.wready = !st_ff.w_hold;
  assign axi_rsp.bvalid = st_ff.bvalid;
  assign axi_rsp.bresp = st_ff.bresp;
  assign axi_rsp.arready = !st_ff.rvalid;
  assign axi_rsp.rvalid = st_ff.rvalid;
  assign axi_rsp.rdata = st_ff.rdata;
  assign axi_rsp.rresp = st_ff.rresp;
  // converter readings and switching stay blocked until the restart after supply return
  assign pwm_allowed = main_supply_ok && !st_ff.restart_need;
  assign adc_valid = main_supply_ok && !st_ff.restart_need;
  assign nvm_store_req = st_ff.store;
  assign iout_gain = st_ff.gain;
  assign rdcr_est = st_ff.rdcr;
  assign irq = |(st_ff.status & st_ff.mask);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_unlock_code: assert property ($rose(st_ff.unlocked) |->
    $past(wr_fire && wr_addr == A_UNLOCK && wr_data[7:0] == UNLOCK_CODE2 && st_ff.armed))
    else $error("unlock without the two-code sequence");
  a_locked_write: assert property (wr_fire && !wr_ok && wr_addr == A_GAIN |=> $stable(st_ff.gain))
    else $error("gain written while locked");
  a_store_pulse: assert property (wr_fire && wr_ok && wr_addr == A_CMD && wr_data[0] && st_ff.w_strb[0]
    |=> nvm_store_req ##1 !nvm_store_req)
    else $error("store request not a single pulse");
  a_pwm_gate: assert property ($rose(pwm_allowed) |-> $past(st_ff.restart_need) == 1'b0
    || $past(wr_fire && wr_addr == A_CMD && wr_data[CMD_RESTART_BIT]))
    else $error("switching allowed without restart");
  a_cal_start: assert property (wr_fire && wr_ok && wr_addr == A_MODE && wr_data[3] && st_ff.w_strb[0]
    && st_ff.cal == CAL_IDLE |=> st_ff.cal == CAL_SETTLE)
    else $error("calibration did not start");
  a_fail_keep: assert property (st_ff.cal == CAL_CHECK && !pre_ok |=> st_ff.status[0] && $stable(st_ff.gain))
    else $error("failed precondition handled wrongly");
  a_gain_source: assert property ($changed(st_ff.gain) |-> $past(wr_fire && wr_addr == A_GAIN)
    || $past(st_ff.cal == CAL_DIV && div_done && in_window))
    else $error("gain changed without write or pass");
  a_bit_clears: assert property ($fell(st_ff.cal != CAL_IDLE) |-> !st_ff.mode[3])
    else $error("start bit left set after calibration");
  a_div_bound: assert property (st_ff.div_go |-> ##[1:60] div_done)
    else $error("divider did not finish");
  a_lag_step: assert property (st_ff.tau == 4'h0 && st_ff.tick_cnt >= TICK_CYCLES - 1
    |=> st_ff.rise == $past(rise_ss))
    else $error("zero lag did not track steady rise");
  a_rdcr_ref: assert property (dtemp == 18'sd0 |=> st_ff.rdcr == $past(st_ff.r0))
    else $error("estimate differs from reference at reference temperature");

  c_cal_pass: cover property (st_ff.cal == CAL_DIV && div_done && in_window);
  c_cal_fail: cover property (st_ff.cal == CAL_CHECK && !pre_ok);
  c_unlock: cover property ($rose(st_ff.unlocked) && !main_supply_ok);
  c_irq: cover property ($rose(irq));
endmodule : idc_dcr_cal

// >>> rtl/idc_pkg.sv
// Purpose: shared constants and types of the inductor resistance calibration block
// Assumes: 100 MHz ref_clk, AXI4-Lite register access, 32-bit data
package idc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SETTLE_MS = 160;
  localparam int unsigned SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned TICK_US = 100;
  localparam int unsigned TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DUTY_MIN_PCT = 3;
  localparam logic [15:0] DUTY_MIN_Q16 = 16'((65536 * DUTY_MIN_PCT + 99) / 100);
  localparam logic [15:0] IIN_MIN_MA = 16'h000A;
  localparam logic [3:0] WIN_LO_TENTHS = 4'h7;
  localparam logic [3:0] WIN_HI_TENTHS = 4'hD;
  localparam logic [7:0] UNLOCK_CODE1 = 8'h2B;
  localparam logic [7:0] UNLOCK_CODE2 = 8'hC4;
  localparam int unsigned CAL_START_BIT = 3;
  localparam int unsigned CMD_STORE_BIT = 0;
  localparam int unsigned CMD_RESTART_BIT = 1;
  localparam int unsigned ST_FAIL_BIT = 0;
  localparam int unsigned ST_PASS_BIT = 1;
  localparam int unsigned PWR_SHIFT = 18;
  localparam int unsigned FRAC_SHIFT = 16;
  localparam logic [7:0] A_UNLOCK = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_MODE = 8'h08;
  localparam logic [7:0] A_GAIN = 8'h0C;
  localparam logic [7:0] A_UNCAL = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_MASK = 8'h18;
  localparam logic [7:0] A_STATE = 8'h1C;
  localparam logic [7:0] A_R0 = 8'h20;
  localparam logic [7:0] A_ALPHA = 8'h24;
  localparam logic [7:0] A_THETA = 8'h28;
  localparam logic [7:0] A_TREF = 8'h2C;
  localparam logic [7:0] A_TAU = 8'h30;
  localparam logic [7:0] A_RDCR = 8'h34;
  localparam logic [15:0] GAIN_RST = 16'h1000;
  localparam logic [15:0] R0_RST = 16'h0900;
  localparam logic [15:0] ALPHA_RST = 16'hFF97;
  localparam logic [15:0] THETA_RST = 16'h0A00;
  localparam logic [15:0] TREF_RST = 16'h1900;
  localparam logic [3:0] TAU_RST = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {CAL_IDLE, CAL_SETTLE, CAL_CHECK, CAL_DIV, CAL_END} idc_cal_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } idc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } idc_axi_rsp_t;

  typedef struct packed {
    logic [15:0] duty;
    logic [15:0] iin;
    logic [15:0] iout;
    logic [15:0] vdcr;
    logic [15:0] temp_s;
  } idc_telem_t;
endpackage : idc_pkg

// >>> rtl/idc_seq_div.sv
// Purpose: unsigned restoring divider, one quotient bit per clock
// Assumes: den nonzero, checked by the caller
// Notes: quotient is held in a register until the next start
`timescale 1ns/1ps
module idc_seq_div
  import idc_pkg::*;
#(
  parameter int NW = 48,
  parameter int DW = 32
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  output logic busy,
  output logic done,
  output logic [NW-1:0] quot
);
  typedef struct packed {
    logic [NW-1:0] q;
    logic [DW:0] rem;
    logic [DW-1:0] d;
    logic [7:0] cnt;
    logic busy;
    logic done;
  } idc_div_t;

  idc_div_t st_ff, nxt_st;
  logic [DW:0] trial;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    trial = {st_ff.rem[DW-1:0], st_ff.q[NW-1]};
    if (start && !st_ff.busy) begin
      nxt_st.q = num;
      nxt_st.d = den;
      nxt_st.rem = '0;
      nxt_st.cnt = 8'(NW);
      nxt_st.busy = 1'b1;
    end else if (st_ff.busy) begin
      if (trial >= {1'b0, st_ff.d}) begin
        nxt_st.rem = trial - {1'b0, st_ff.d};
        nxt_st.q = {st_ff.q[NW-2:0], 1'b1};
      end else begin
        nxt_st.rem = trial;
        nxt_st.q = {st_ff.q[NW-2:0], 1'b0};
      end
      nxt_st.cnt = st_ff.cnt - 8'h01;
      if (st_ff.cnt == 8'h01) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;
  assign done = st_ff.done;
  assign quot = st_ff.q;
endmodule : idc_seq_div

// >>> verif/idc_stage_model.sv
// Purpose: power stage stand-in that turns a true load current into sensed readings
// Assumes: the bench holds every input steady while a calibration runs
// Notes: dcr_err scales the sensed output current as Q4.12, so 0x1000 means an exact inductor resistance
`timescale 1ns/1ps
module idc_stage_model
  import idc_pkg::*;
(
  input wire logic [15:0] load_ma,
  input wire logic [15:0] duty,
  input wire logic [15:0] dcr_err,
  input wire logic [15:0] gain,
  input wire logic [15:0] vdcr,
  input wire logic [15:0] temp_s,
  output idc_telem_t telem
);
  logic [47:0] sensed;
  logic [31:0] drawn;
  // readings follow bench-held inputs and the DUT gain, which cannot be written mid-run, so the operating point stays put through settling
  always_comb begin
    sensed = 48'(load_ma) * 48'(gain) * 48'(dcr_err);
    drawn = 32'(load_ma) * 32'(duty);
    telem.duty = duty;
    telem.iin = drawn[31:16]; // input current is load times duty
    telem.iout = sensed[39:24];
    telem.vdcr = vdcr;
    telem.temp_s = temp_s;
  end
endmodule : idc_stage_model

// >>> verif/tb.sv
// Purpose: self-checking bench for the resistance calibration block
// Assumes: short settle and tick counts keep the run brief
// Notes: random loads and duties from seed 32, corner cases from a table
`timescale 1ns/1ps
module tb;
  import idc_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  idc_axi_req_t req = '0;
  idc_axi_rsp_t rsp;
  idc_telem_t telem;
  logic main_supply_ok = 1'b0;
  logic pwm_enabled = 1'b0; // run stays low until configured
  logic pwm_allowed, adc_valid, nvm_store_req, irq;
  logic [15:0] iout_gain, rdcr_est, load_ma = 16'h0000, duty = 16'h0000, dcr_err = 16'h1000;
  logic [15:0] vdcr = 16'h0000, temp_s = TREF_RST, exp_gain = GAIN_RST, r_early;
  logic [31:0] rd;
  logic [1:0] last_resp;
  int mismatches = 0, total_checks = 0, cyc = 0, stores = 0;
  logic [7:0] ra [10] = '{A_GAIN, A_UNCAL, A_STATUS, A_MASK, A_R0, A_ALPHA, A_THETA, A_TREF, A_TAU, A_MODE};
  logic [15:0] rv [10] = '{GAIN_RST, GAIN_RST, 16'h0000, 16'h0000, R0_RST, ALPHA_RST, THETA_RST, TREF_RST,
    16'(TAU_RST), 16'h0000};
  logic [15:0] cl [6] = '{16'h1388, 16'h1388, 16'h0013, 16'h0014, 16'h1F40, 16'h1F40};
  logic [15:0] cd [6] = '{16'h07AE, 16'h07AF, 16'h8000, 16'h8000, 16'h8000, 16'h8000};
  logic [15:0] ce [6] = '{16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h1999};
  logic cp [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

  always #5 ref_clk = ~ref_clk;

  idc_dcr_cal #(.SETTLE_CYCLES(20), .TICK_CYCLES(4)) idc_dcr_cal_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .axi_req(req), .axi_rsp(rsp), .telem(telem), .main_supply_ok(main_supply_ok), .pwm_enabled(pwm_enabled),
    .pwm_allowed(pwm_allowed), .adc_valid(adc_valid), .nvm_store_req(nvm_store_req), .iout_gain(iout_gain),
    .rdcr_est(rdcr_est), .irq(irq));

  idc_stage_model idc_stage_model_inst (.load_ma(load_ma), .duty(duty), .dcr_err(dcr_err), .gain(iout_gain),
    .vdcr(vdcr), .temp_s(temp_s), .telem(telem));

  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // the cycle ceiling is far above the about 1200 cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (nvm_store_req === 1'b1) stores++;
    if (cyc == 30000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        last_resp = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        rd = rsp.rdata;
        last_resp = rsp.rresp;
        req.rready <= 1'b0;
        break;
      end
    end
  endtask : axi_read

  // one calibration run; pass or fail and the new gain are predicted from the sensed readings
  task automatic run_cal(input logic [15:0] l, input logic [15:0] d, input logic [15:0] e, input logic p);
    longint den, q;
    logic ok;
    load_ma <= l;
    duty <= d;
    dcr_err <= e;
    pwm_enabled <= p;
    axi_write(A_STATUS, 32'h3);
    den = longint'(telem.iout) * longint'(d);
    ok = p && d >= DUTY_MIN_Q16 && telem.iin >= IIN_MIN_MA && den != 0;
    q = ok ? longint'(exp_gain) * longint'(telem.iin) * 65536 / den : 0;
    ok = ok && q * 10 >= WIN_LO_TENTHS * GAIN_RST && q * 10 <= WIN_HI_TENTHS * GAIN_RST && q <= 65535;
    if (ok) exp_gain = q[15:0];
    axi_write(A_MODE, 32'h8);
    do axi_read(A_MODE); while (rd[CAL_START_BIT] !== 1'b0);
    chk("mode_start", 32'h0, rd);
    chk("gain", 32'(exp_gain), 32'(iout_gain));
    axi_read(A_STATUS);
    chk("status", {30'h0, ok, !ok}, rd);
    chk("irq", 32'(!ok), 32'(irq));
  endtask : run_cal

  function automatic logic [15:0] exp_rdcr(input logic [15:0] dt);
    longint p;
    p = (longint'(ALPHA_RST) * longint'($signed(dt))) >>> 16;
    p = longint'(R0_RST) + ((longint'(R0_RST) * p) >>> 16);
    return p > 65535 ? 16'hFFFF : (p < 0 ? 16'h0000 : p[15:0]);
  endfunction : exp_rdcr

  initial begin
    void'($urandom(32));
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      axi_read(ra[i]);
      chk("reset_value", 32'(rv[i]), rd);
    end
    axi_read(8'h38);
    chk("unmapped_resp", 32'(RESP_SLVERR), 32'(last_resp));
    chk("unmapped_data", 32'h0, rd);
    $display("test reset_values done");
    axi_write(A_GAIN, 32'h1234);
    axi_read(A_GAIN);
    chk("locked_gain", 32'(GAIN_RST), rd);
    axi_write(A_UNLOCK, 32'(UNLOCK_CODE1));
    axi_write(A_UNLOCK, 32'h11);
    axi_write(A_UNLOCK, 32'(UNLOCK_CODE2));
    axi_read(A_UNLOCK);
    chk("unlock_broken", 32'h0, rd);
    axi_write(A_UNLOCK, 32'(UNLOCK_CODE1));
    axi_write(A_UNLOCK, 32'(UNLOCK_CODE2));
    axi_read(A_UNLOCK);
    chk("unlocked", 32'h1, rd);
    axi_write(A_MASK, 32'h1);
    chk("pwm_allowed_off", 32'h0, 32'(pwm_allowed));
    $display("test bring_up done");
    main_supply_ok <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("pwm_before_restart", 32'h0, 32'({pwm_allowed, adc_valid}));
    axi_write(A_CMD, 32'h2);
    @(posedge ref_clk);
    chk("pwm_after_restart", 32'h3, 32'({pwm_allowed, adc_valid}));
    axi_read(A_STATE);
    chk("state_word", 32'h3, rd);
    chk("no_store_yet", 32'h0, 32'(stores));
    axi_write(A_CMD, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk("store_pulses", 32'h1, 32'(stores));
    $display("test restart_store done");
    for (int i = 0; i < 3; i++)
      run_cal(16'($urandom_range(1000, 20000)), 16'($urandom_range(16'h2000, 16'hC000)),
        16'($urandom_range(16'h0E00, 16'h1200)), 1'b1);
    for (int i = 0; i < 6; i++) run_cal(cl[i], cd[i], ce[i], cp[i]);
    $display("test calibration done");
    axi_write(A_MASK, 32'h0);
    chk("irq_masked", 32'h0, 32'(irq));
    axi_write(A_MASK, 32'h1);
    chk("irq_unmasked", 32'h1, 32'(irq));
    axi_write(A_STATUS, 32'h1);
    chk("irq_cleared", 32'h0, 32'(irq));
    $display("test interrupt done");
    for (int i = 0; i < 4; i++) begin
      rd = (i == 0) ? 32'h0 : 32'($urandom_range(1, 16'h2000));
      temp_s <= TREF_RST + rd[15:0];
      repeat (12) @(posedge ref_clk);
      chk("rdcr", 32'(exp_rdcr(rd[15:0])), 32'(rdcr_est));
    end
    temp_s <= TREF_RST;
    load_ma <= 16'h1388;
    axi_write(A_TAU, 32'h4);
    vdcr <= 16'h0010;
    repeat (6) @(posedge ref_clk);
    r_early = rdcr_est;
    repeat (400) @(posedge ref_clk);
    chk("rdcr_lags", 32'h1, 32'(r_early < rdcr_est));
    axi_write(A_TAU, 32'h0);
    repeat (8) @(posedge ref_clk);
    chk("rdcr_rises", 32'h1, 32'(rdcr_est > R0_RST));
    $display("test thermal done");
    conclude();
  end
endmodule : tb
